// file: rtl/frs_pkg.sv
/*
 * Shared constants and carrier types for the field reference and
 * format select front end.
 * Assumes a single 40 MHz core clock and a synchronous active-high reset.
 */
package frs_pkg;

    // ==================================================================
    // Widths and counts
    // ==================================================================
    localparam int unsigned FMT_W        = 6;
    localparam int unsigned SYNC_STAGES  = 2;
    localparam int unsigned VID_CLOCKS   = 8;
    localparam int unsigned GFX_CLOCKS   = 13;
    localparam int unsigned VID_FORMATS  = 35;
    localparam int unsigned GFX_FORMATS  = 13;
    localparam int unsigned STABLE_COUNT = 4;
    localparam logic [2:0]  STABLE_LAST  = 3'h3;

    // ==================================================================
    // Reset values
    // ==================================================================
    localparam logic [5:0]  FMT_RESET    = 6'h00;
    localparam logic [2:0]  CNT_RESET    = 3'h0;

    // ==================================================================
    // Format classes
    // ==================================================================
    typedef enum logic [3:0] {
        FRS_CLASS_NONE  = 4'b0001,
        FRS_CLASS_VIDEO = 4'b0010,
        FRS_CLASS_GFX   = 4'b0100,
        FRS_CLASS_BAD   = 4'b1000
    } frs_class_t;

    // ==================================================================
    // Carriers
    // ==================================================================
    typedef struct packed {
        logic [5:0] code;
        logic       video;
        logic       graphics;
        logic       valid;
    } frs_format_t;

    typedef struct packed {
        logic       present;
        logic       first_field;
        logic       field_edge;
    } frs_field_t;

    // ==================================================================
    // Code map: 0 none, 1..35 video, 36..48 graphics, rest unsupported
    // ==================================================================
    localparam logic [5:0]  VID_FIRST    = 6'h01;
    localparam logic [5:0]  VID_LAST     = 6'h23;
    localparam logic [5:0]  GFX_FIRST    = 6'h24;
    localparam logic [5:0]  GFX_LAST     = 6'h30;

endpackage : frs_pkg

// file: rtl/frs_sync.sv
/*
 * Two-stage level synchroniser of parameterised width.
 * Assumes the input is asynchronous to core_clk_i.
 */
`timescale 1ns/1ps
module frs_sync #(
    parameter int unsigned WIDTH = 1
) (
    input  wire logic             core_clk_i,
    input  wire logic             reset_i,
    input  wire logic [WIDTH-1:0] async_i,
    output logic      [WIDTH-1:0] sync_o
);
    logic [WIDTH-1:0] meta;

    // ==================================================================
    // Synchroniser
    // ==================================================================
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            meta   <= '0;
            sync_o <= '0;
        end else begin
            meta   <= async_i;
            sync_o <= meta;
        end
    end

endmodule : frs_sync

// file: rtl/frs_front.sv
/*
 * Field reference and format select front end of a video timing generator.
 * Assumes field_ref_in and format_select arrive from pins, asynchronous
 * to core_clk_i, and that the reference source keeps its own conventions.
 */
`timescale 1ns/1ps
module frs_front
    import frs_pkg::*;
(
    input  wire logic                core_clk_i,
    input  wire logic                reset_i,
    input  wire logic                field_ref_in_i,
    input  wire logic [5:0]          format_select_i,
    input  wire logic                blanking_ref_i,
    output frs_pkg::frs_format_t     format_o,
    output frs_pkg::frs_field_t      field_o,
    output logic                     format_change_o
);
    import frs_pkg::*;

    logic       field_s;
    logic [5:0] fmt_s;
    logic       blank_s;
    logic       field_d;
    logic [5:0] fmt_cand;
    logic [2:0] fmt_cnt;
    logic       seen_high;
    frs_class_t fmt_class;

    // ==================================================================
    // Code classification
    // ==================================================================
    function automatic frs_class_t classify(input logic [5:0] c);
        if (c == FMT_RESET) begin
            classify = FRS_CLASS_NONE;
        end else if (c >= VID_FIRST && c <= VID_LAST) begin
            classify = FRS_CLASS_VIDEO;
        end else if (c >= GFX_FIRST && c <= GFX_LAST) begin
            classify = FRS_CLASS_GFX;
        end else begin
            classify = FRS_CLASS_BAD;
        end
    endfunction : classify

    // ==================================================================
    // Synchronisers
    // ==================================================================
    frs_sync #(.WIDTH(8)) u_sync (
        .core_clk_i (core_clk_i),
        .reset_i    (reset_i),
        .async_i    ({blanking_ref_i, field_ref_in_i, format_select_i}),
        .sync_o     ({blank_s, field_s, fmt_s})
    );

    // ==================================================================
    // Format select debounce
    // ==================================================================
    // A multi-bit pin bus can be caught mid-transition, so a new code is
    // accepted only after it has held for several cycles.
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            fmt_cand <= FMT_RESET;
            fmt_cnt  <= CNT_RESET;
        end else if (fmt_s != fmt_cand) begin
            fmt_cand <= fmt_s;
            fmt_cnt  <= CNT_RESET;
        end else if (fmt_cnt != STABLE_LAST) begin
            fmt_cnt  <= fmt_cnt + 3'h1;
        end
    end

    assign fmt_class = classify(fmt_cand);

    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            format_o        <= '0;
            format_change_o <= 1'b0;
        end else begin
            format_change_o <= 1'b0;
            if (fmt_cnt == STABLE_LAST && format_o.code != fmt_cand) begin
                format_o.code     <= fmt_cand;
                format_o.video    <= (fmt_class == FRS_CLASS_VIDEO);
                format_o.graphics <= (fmt_class == FRS_CLASS_GFX);
                format_o.valid    <= (fmt_class == FRS_CLASS_VIDEO)
                                   || (fmt_class == FRS_CLASS_GFX);
                format_change_o   <= 1'b1;
            end
        end
    end

    // ==================================================================
    // Field identification
    // ==================================================================
    // A reference that never goes high is treated as absent, which is
    // what a source without field sync presents.
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            field_d   <= 1'b0;
            seen_high <= 1'b0;
            field_o   <= '0;
        end else begin
            field_d <= field_s;
            if (field_s) begin
                seen_high <= 1'b1;
            end
            field_o.present     <= seen_high | field_s;
            // Sync-based: high marks the first field; blanking-based: high
            // marks the second, so the sense is inverted.
            field_o.first_field <= (seen_high | field_s)
                                 & (field_s ^ blank_s);
            field_o.field_edge  <= field_s ^ field_d;
        end
    end

endmodule : frs_front

// file: test/frs_front_sva.sv
/* Port checker for frs_front.
   Assumes it is bound to the design from the bench top. */
`timescale 1ns/1ps
module frs_front_sva
    import frs_pkg::*;
(
    input wire logic           core_clk_i,
    input wire logic           reset_i,
    input wire logic           field_ref_in_i,
    input wire logic [5:0]     format_select_i,
    input wire logic           blanking_ref_i,
    input frs_pkg::frs_format_t format_o,
    input frs_pkg::frs_field_t  field_o,
    input wire logic           format_change_o
);
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (reset_i);
    // ======
    // Checks
    property p_pol;
        field_o.present && !$past(reset_i, 3) |->
            field_o.first_field == ($past(field_ref_in_i, 3) ^ $past(blanking_ref_i, 3));
    endproperty
    a_pol: assert property (p_pol) else $error("field polarity wrong");
    property p_edge;
        field_o.field_edge |-> $past(field_ref_in_i, 3) != $past(field_ref_in_i, 4);
    endproperty
    a_edge: assert property (p_edge) else $error("field edge without change");
    property p_fmt;
        format_change_o |-> format_o.code == $past(format_select_i, 7);
    endproperty
    a_fmt: assert property (p_fmt) else $error("format code or latency wrong");
    property p_cls;
        format_o.valid == (format_o.code inside {[VID_FIRST:GFX_LAST]}) &&
            format_o.video == (format_o.code inside {[VID_FIRST:VID_LAST]});
    endproperty
    a_cls: assert property (p_cls) else $error("format class wrong");
    // A settled pin must leave the accepted format code alone.
    property p_hold;
        $stable(format_select_i)[*8] |-> $stable(format_o.code);
    endproperty
    a_hold: assert property (p_hold) else $error("format moved while pins settled");
endmodule : frs_front_sva

// file: test/frs_ref_src.sv
/* Model of the reference source, a sync separator or deserializer.
   Assumes the bench steers its controls at the clock edge. */
`timescale 1ns/1ps
module frs_ref_src (
    input  wire logic       first_i,
    input  wire logic       blank_i,
    input  wire logic       none_i,
    input  wire logic [5:0] code_i,
    output logic            ref_o,
    output logic      [5:0] fmt_o
);
    // High in the first field, or the second for blanking-based.
    // Without field sync the pin is held low.
    assign ref_o = none_i ? 1'b0 : (first_i ^ blank_i);
    // The bench offers unsupported codes only to test that they are taken with valid low.
    assign fmt_o = code_i;
endmodule : frs_ref_src

// file: test/tb_frs_front.sv
/* Bench for frs_front with a reference source model.
   Assumes the checker and model files are compiled first. */
`timescale 1ns/1ps
module tb_frs_front;
    import frs_pkg::*;
    logic clk = 0, rst = 1, blank = 0, fld = 0, none = 0, ref_w, chg;
    logic [5:0] code = 6'h00, sel_w;
    frs_format_t fmt;
    frs_field_t fo;
    int error_cnt = 0, compares = 0;
    logic [5:0] cl [7] = '{6'h01, 6'h23, 6'h24, 6'h30, 6'h31, 6'h3F, 6'h00};
    initial forever #12.5 clk = ~clk;
    frs_ref_src src (.first_i(fld), .blank_i(blank), .none_i(none), .code_i(code),
        .ref_o(ref_w), .fmt_o(sel_w));
    frs_front dut (.core_clk_i(clk), .reset_i(rst), .field_ref_in_i(ref_w),
        .format_select_i(sel_w), .blanking_ref_i(blank), .format_o(fmt),
        .field_o(fo), .format_change_o(chg));
    task automatic check(input logic [9:0] seen, input logic [9:0] exp);
        compares++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask : check
    task automatic wt(input int n, input bit s = 0);
        repeat (n) @(posedge clk);
        if (s) #1;
    endtask : wt
    task automatic conclude;
        $display("compares %0d error_cnt %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : conclude
    // Field change lands three edges on, with a one-cycle edge pulse.
    task automatic t_field(input logic b);
        @(posedge clk);
        blank <= b; fld <= 1'b0; none <= 1'b0;
        wt(6);
        fld <= 1'b1;
        wt(3, 1);
        check({7'h0, fo}, 10'h007);
        wt(1, 1);
        check({7'h0, fo}, 10'h006);
        $display("field test done");
    endtask : t_field
    task automatic t_none;
        @(posedge clk);
        none <= 1'b1;
        wt(4, 1);
        check({7'h0, fo}, {7'h0, 1'b1, blank, 1'b0});
        $display("no field test done");
    endtask : t_none
    task automatic t_fmt(input logic [5:0] c);
        logic v, g;
        v = c inside {[VID_FIRST:VID_LAST]};
        g = c inside {[GFX_FIRST:GFX_LAST]};
        @(posedge clk);
        code <= c;
        wt(7, 1);
        check({fmt, chg}, {c, v, g, v | g, 1'b1});
        wt(1, 1);
        check({9'h0, chg}, 10'h000);
    endtask : t_fmt
    // A code held under four cycles is refused.
    task automatic t_glitch;
        @(posedge clk);
        code <= 6'h05;
        wt(2);
        code <= 6'h00;
        wt(5, 1);
        check({fmt, chg}, 10'h000);
        wt(7, 1);
        check({4'h0, fmt.code}, 10'h000);
        $display("glitch test done");
    endtask : t_glitch
    initial begin
        wt(16);
        rst <= 1'b0;
        wt(2, 1);
        check({7'h0, fo}, 10'h000);
        t_field(1'b0);
        t_none();
        t_field(1'b1);
        foreach (cl[i]) t_fmt(cl[i]);
        $display("format test done");
        t_glitch();
        conclude();
    end
    initial begin
        wt(3000);
        error_cnt++;
        conclude();
    end
endmodule : tb_frs_front
bind frs_front frs_front_sva chk (.core_clk_i(core_clk_i), .reset_i(reset_i),
    .field_ref_in_i(field_ref_in_i), .format_select_i(format_select_i),
    .blanking_ref_i(blanking_ref_i), .format_o(format_o), .field_o(field_o),
    .format_change_o(format_change_o));
